// [include/xbcr_pkg.sv]
// Constants, bank states and command codes for the cross-bank command checker.
// Assumes every timing figure is counted on the memory clock at the link period below.
package xbcr_pkg;
    localparam int NUM_BANKS = 8;
    localparam int LINK_PERIOD_PS = 15000;
    localparam int READ_LATENCY = 5;
    localparam int BURST_LEN = 4;
    localparam int PRECHARGE_TIME_PS = 15000;
    localparam int ACTIVATE_TO_ACCESS_DELAY_PS = 15000;
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam int WRITE_TO_READ_DELAY_PS = 7500;
    localparam int SELF_REFRESH_EXIT_DELAY_PS = 127500;

    // Least times round up and never come to less than one cycle.
    function automatic int cyc_up(input int t_ps);
        int c;
        c = (t_ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WTR_RAW = cyc_up(WRITE_TO_READ_DELAY_PS);
    localparam logic [7:0] TRP_CYC = 8'(cyc_up(PRECHARGE_TIME_PS));
    localparam logic [7:0] ACTIVATE_TO_ACCESS_DELAY_CYC = 8'(cyc_up(ACTIVATE_TO_ACCESS_DELAY_PS));
    localparam logic [7:0] TWR_CYC = 8'(cyc_up(WRITE_RECOVERY_TIME_PS));
    localparam logic [7:0] XSNR_CYC = 8'(cyc_up(SELF_REFRESH_EXIT_DELAY_PS));
    localparam logic [7:0] WTR_CYC = 8'((WTR_RAW > 2) ? WTR_RAW : 2);
    localparam logic [7:0] HALF_BURST_CYC = 8'(BURST_LEN / 2);
    localparam logic [7:0] RD_BURST_CYC = 8'(READ_LATENCY + BURST_LEN / 2);
    localparam logic [7:0] WR_BURST_CYC = 8'(READ_LATENCY - 1 + BURST_LEN / 2);
    localparam logic [7:0] WR_AP_ACCESS_CYC = WR_BURST_CYC + TWR_CYC;
    localparam logic [7:0] RD_TAIL_CYC = RD_BURST_CYC - HALF_BURST_CYC;
    localparam logic [7:0] RD_AP_PRE_CYC = (TRP_CYC > RD_TAIL_CYC) ? TRP_CYC : RD_TAIL_CYC;
    localparam logic [7:0] RD_TO_WR_CYC = HALF_BURST_CYC + 8'h02;
    localparam logic [7:0] WR_TO_RD_CYC = WR_BURST_CYC + WTR_CYC;
    localparam logic [7:0] PRE_ACT_GAP_CYC = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    typedef enum logic [2:0] {
        BK_IDLE = 3'h0,
        BK_ACTIVATING = 3'h1,
        BK_ACTIVE = 3'h2,
        BK_READ = 3'h3,
        BK_WRITE = 3'h4,
        BK_READ_AP = 3'h5,
        BK_WRITE_AP = 3'h6,
        BK_PRECHARGE = 3'h7
    } xbcr_bank_t;

    // Codes are the row, column and write strobes, active low, in that order.
    typedef enum logic [2:0] {
        CMD_LOAD_MODE = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ = 3'h5,
        CMD_RSVD = 3'h6,
        CMD_NOP = 3'h7
    } xbcr_cmd_t;

    function automatic logic rw_ok(input xbcr_bank_t s);
        return (s == BK_ACTIVE) || (s == BK_READ) || (s == BK_WRITE);
    endfunction

    function automatic logic pre_ok(input xbcr_bank_t s);
        return (s != BK_ACTIVATING) && (s != BK_READ_AP) && (s != BK_WRITE_AP);
    endfunction
endpackage

// [logic/xbcr_bank.sv]
// State and timers of one bank, clocked by the memory clock.
// Assumes the caller only raises a command strobe that this bank's state allows.
`timescale 1ns/1ps
module xbcr_bank
    import xbcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic do_act,
    input wire logic do_rd,
    input wire logic do_wr,
    input wire logic do_pre,
    input wire logic ap,
    output xbcr_bank_t state
);
    logic [7:0] cnt;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= BK_IDLE;
            cnt <= 8'h00;
        end
        else
        begin
            case (state)
                BK_IDLE:
                begin
                    if (do_act)
                    begin
                        state <= BK_ACTIVATING;
                        cnt <= ACTIVATE_TO_ACCESS_DELAY_CYC - 8'h01;
                    end
                end
                BK_ACTIVATING:
                begin
                    if (cnt == 8'h00)
                        state <= BK_ACTIVE;
                    else
                        cnt <= cnt - 8'h01;
                end
                BK_ACTIVE, BK_READ, BK_WRITE:
                begin
                    if (do_rd)
                    begin
                        state <= ap ? BK_READ_AP : BK_READ;
                        cnt <= (ap ? HALF_BURST_CYC : RD_BURST_CYC) - 8'h01;
                    end
                    else if (do_wr)
                    begin
                        state <= ap ? BK_WRITE_AP : BK_WRITE;
                        cnt <= (ap ? WR_AP_ACCESS_CYC : WR_BURST_CYC) - 8'h01;
                    end
                    else if (do_pre)
                    begin
                        state <= BK_PRECHARGE;
                        cnt <= TRP_CYC - 8'h01;
                    end
                    else if (state != BK_ACTIVE)
                    begin
                        if (cnt == 8'h00)
                            state <= BK_ACTIVE;
                        else
                            cnt <= cnt - 8'h01;
                    end
                end
                BK_READ_AP:
                begin
                    // The row may not close before the read data is out either.
                    if (cnt == 8'h00)
                    begin
                        state <= BK_PRECHARGE;
                        cnt <= RD_AP_PRE_CYC - 8'h01;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                BK_WRITE_AP:
                begin
                    if (cnt == 8'h00)
                    begin
                        state <= BK_PRECHARGE;
                        cnt <= TRP_CYC - 8'h01;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                BK_PRECHARGE:
                begin
                    // A later precharge restarts the period.
                    if (do_pre)
                        cnt <= TRP_CYC - 8'h01;
                    else if (cnt == 8'h00)
                        state <= BK_IDLE;
                    else
                        cnt <= cnt - 8'h01;
                end
                default:
                begin
                    state <= BK_IDLE;
                    cnt <= 8'h00;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    act_open_a: assert property (state == BK_IDLE && do_act |=> state == BK_ACTIVATING)
        else $error("Activate did not open the bank.");
    active_src_a: assert property (state == BK_ACTIVE |-> $past(state) != BK_IDLE)
        else $error("Bank became active straight from idle.");
    // Unknown history before the link reset settles never counts as a change into idle.
    idle_src_a: assert property (state == BK_IDLE && $past(state) != BK_IDLE
        |-> $past(state) == BK_PRECHARGE)
        else $error("Bank became idle without precharge.");
    burst_st_a: assert property (rw_ok(state) && do_rd && !ap |=> state == BK_READ [*2])
        else $error("Read burst did not hold the read state.");
    rdap_pre_a: assert property (rw_ok(state) && do_rd && ap
        |=> (state == BK_READ_AP) [*2] ##1 state == BK_PRECHARGE)
        else $error("Read auto precharge period misplaced.");
    wrap_rec_a: assert property (rw_ok(state) && do_wr && ap
        |=> (state == BK_WRITE_AP) [*7] ##1 state == BK_PRECHARGE)
        else $error("Write auto precharge ignored recovery time.");
endmodule // xbcr_bank

// [logic/xbcr_sync.sv]
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit changes slowly against the destination clock.
`timescale 1ns/1ps
module xbcr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk)
    begin
        meta <= d;
        q <= meta;
    end
endmodule // xbcr_sync

// [logic/xbcr_top.sv]
// Cross-bank command decoder and checker of the memory, with status on the system clock.
// Assumes the command pins change on the memory clock that also clocks the link side.
`timescale 1ns/1ps
module xbcr_top
    import xbcr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mem_clk,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic auto_precharge_addr_bit,
    input wire logic err_clear,
    output logic [NUM_BANKS-1:0] bank_idle,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic self_refresh,
    output logic state_error,
    output logic timing_error
);
    logic rst_link;
    logic cke_prev;
    logic in_sr;
    logic [7:0] xsnr_cnt;
    logic live;
    logic sel;
    xbcr_cmd_t cmd;
    xbcr_bank_t bank_state [NUM_BANKS];
    logic [NUM_BANKS-1:0] do_act;
    logic [NUM_BANKS-1:0] do_rd;
    logic [NUM_BANKS-1:0] do_wr;
    logic [NUM_BANKS-1:0] do_pre;
    logic [NUM_BANKS-1:0] idle_vec;
    logic [NUM_BANKS-1:0] open_vec;
    logic all_idle;
    logic exec_any;
    xbcr_bank_t tgt_state;
    logic own_bad;
    logic gap_bad;
    logic [7:0] since_rw;
    logic seen_rw;
    logic last_wr;
    logic state_err_t;
    logic timing_err_t;
    logic [NUM_BANKS-1:0] link_idle;
    logic [NUM_BANKS-1:0] link_open;
    logic [2*NUM_BANKS+2:0] sys_sync;
    logic prev_state_t;
    logic prev_timing_t;

    // The system reset reaches the link side through its own synchroniser.
    xbcr_sync #(
        .W(1)
    ) u_rst_sync (
        .clk(mem_clk),
        .d(reset),
        .q(rst_link)
    );

    assign cmd = xbcr_cmd_t'({ras_n, cas_n, we_n});
    assign live = cke && cke_prev && (xsnr_cnt == 8'h00) && !rst_link;
    assign sel = live && !cs_n;

    always_ff @(posedge mem_clk)
    begin
        if (rst_link)
            cke_prev <= 1'b0;
        else
            cke_prev <= cke;
    end

    // Self refresh is entered with a refresh while clock enable falls.
    always_ff @(posedge mem_clk)
    begin
        if (rst_link)
        begin
            in_sr <= 1'b0;
            xsnr_cnt <= 8'h00;
        end
        else if (in_sr && cke)
        begin
            in_sr <= 1'b0;
            xsnr_cnt <= XSNR_CYC;
        end
        else if (cke_prev && !cke && !cs_n && cmd == CMD_REFRESH)
            in_sr <= 1'b1;
        else if (xsnr_cnt != 8'h00)
            xsnr_cnt <= xsnr_cnt - 8'h01;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++)
        begin : g_bank
            logic tgt;
            assign tgt = (ba == 3'(gi));
            // Other banks never veto these four commands; only the target's own state does.
            assign do_act[gi] = sel && cmd == CMD_ACTIVATE && tgt
                && bank_state[gi] == BK_IDLE;
            assign do_rd[gi] = sel && cmd == CMD_READ && tgt && rw_ok(bank_state[gi]);
            assign do_wr[gi] = sel && cmd == CMD_WRITE && tgt && rw_ok(bank_state[gi]);
            assign do_pre[gi] = sel && cmd == CMD_PRECHARGE
                && (tgt || auto_precharge_addr_bit) && pre_ok(bank_state[gi]);
            assign idle_vec[gi] = bank_state[gi] == BK_IDLE;
            assign open_vec[gi] = rw_ok(bank_state[gi]);

            xbcr_bank u_bank (
                .clk(mem_clk),
                .rst(rst_link),
                .do_act(do_act[gi]),
                .do_rd(do_rd[gi]),
                .do_wr(do_wr[gi]),
                .do_pre(do_pre[gi]),
                .ap(auto_precharge_addr_bit),
                .state(bank_state[gi])
            );
        end
    endgenerate

    assign all_idle = &idle_vec;
    assign exec_any = |(do_act | do_rd | do_wr | do_pre);
    assign tgt_state = bank_state[ba];

    // A refused command is dropped, so the banks never leave a defined state.
    always_comb
    begin
        own_bad = 1'b0;
        if (sel)
        begin
            case (cmd)
                CMD_ACTIVATE: own_bad = tgt_state != BK_IDLE;
                CMD_READ, CMD_WRITE: own_bad = !rw_ok(tgt_state);
                CMD_PRECHARGE: own_bad = !auto_precharge_addr_bit && !pre_ok(tgt_state);
                CMD_REFRESH, CMD_LOAD_MODE: own_bad = !all_idle;
                CMD_RSVD: own_bad = 1'b1;
                default: own_bad = 1'b0;
            endcase
        end
    end

    // Gaps to precharge or activate are one cycle, which every later edge already meets.
    always_comb
    begin
        gap_bad = 1'b0;
        if (seen_rw && (|do_rd))
            gap_bad = since_rw < (last_wr ? WR_TO_RD_CYC : HALF_BURST_CYC);
        else if (seen_rw && (|do_wr))
            gap_bad = since_rw < (last_wr ? HALF_BURST_CYC : RD_TO_WR_CYC);
    end

    always_ff @(posedge mem_clk)
    begin
        if (rst_link)
        begin
            since_rw <= 8'h00;
            seen_rw <= 1'b0;
            last_wr <= 1'b0;
        end
        else if (|(do_rd | do_wr))
        begin
            since_rw <= PRE_ACT_GAP_CYC;
            seen_rw <= 1'b1;
            last_wr <= |do_wr;
        end
        else if (since_rw != COUNT_MAX)
            since_rw <= since_rw + 8'h01;
    end

    // Errors cross as toggles so that no event is lost between clocks.
    always_ff @(posedge mem_clk)
    begin
        if (rst_link)
        begin
            state_err_t <= 1'b0;
            timing_err_t <= 1'b0;
        end
        else
        begin
            if (own_bad)
                state_err_t <= !state_err_t;
            if (gap_bad)
                timing_err_t <= !timing_err_t;
        end
    end

    always_ff @(posedge mem_clk)
    begin
        if (rst_link)
        begin
            link_idle <= '1;
            link_open <= '0;
        end
        else
        begin
            link_idle <= idle_vec;
            link_open <= open_vec;
        end
    end

    // Status bits cross one by one; a snapshot may mix two adjacent link cycles.
    xbcr_sync #(
        .W(2 * NUM_BANKS + 3)
    ) u_stat_sync (
        .clk(clk_sys),
        .d({link_idle, link_open, in_sr, state_err_t, timing_err_t}),
        .q(sys_sync)
    );

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bank_idle <= '1;
            bank_open <= '0;
            self_refresh <= 1'b0;
        end
        else
        begin
            bank_idle <= sys_sync[2*NUM_BANKS+2:NUM_BANKS+3];
            bank_open <= sys_sync[NUM_BANKS+2:3];
            self_refresh <= sys_sync[2];
        end
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prev_state_t <= 1'b0;
            prev_timing_t <= 1'b0;
            state_error <= 1'b0;
            timing_error <= 1'b0;
        end
        else
        begin
            prev_state_t <= sys_sync[1];
            prev_timing_t <= sys_sync[0];
            if (sys_sync[1] != prev_state_t)
                state_error <= 1'b1;
            else if (err_clear)
                state_error <= 1'b0;
            if (sys_sync[0] != prev_timing_t)
                timing_error <= 1'b1;
            else if (err_clear)
                timing_error <= 1'b0;
        end
    end

    deselect_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        cs_n |-> !exec_any)
        else $error("Command ran while deselected.");
    nop_cmd_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        !cs_n && cmd == CMD_NOP |-> !exec_any && !own_bad)
        else $error("No-operation started something.");
    cke_gate_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        !(cke && cke_prev) |-> !exec_any)
        else $error("Command ran with clock enable low.");
    sr_exit_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        in_sr && cke |=> (!exec_any) [*8])
        else $error("Command ran inside the self-refresh exit delay.");
    idle_fire_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        sel && cmd == CMD_ACTIVATE && tgt_state == BK_IDLE |=> bank_state[$past(ba)] == BK_ACTIVATING)
        else $error("Activate to an idle bank was refused.");
    cross_ok_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        sel && cmd == CMD_WRITE && rw_ok(tgt_state) |-> do_wr[ba] && !own_bad)
        else $error("Write allowed by the bank's state was blocked.");
    a10_ap_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        (|do_rd) && auto_precharge_addr_bit |=> bank_state[$past(ba)] == BK_READ_AP)
        else $error("Address bit ten did not select auto precharge.");
    rd_wr_gap_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        (|do_wr) && seen_rw && !last_wr && since_rw < RD_TO_WR_CYC
        |=> timing_err_t != $past(timing_err_t))
        else $error("Early write after read went unflagged.");
    wr_rd_gap_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        (|do_rd) && seen_rw && last_wr && since_rw < WR_TO_RD_CYC
        |=> timing_err_t != $past(timing_err_t))
        else $error("Early read after write went unflagged.");
    ref_idle_a: assert property (@(posedge mem_clk) disable iff (rst_link)
        sel && cmd == CMD_REFRESH && !all_idle |=> state_err_t != $past(state_err_t))
        else $error("Refresh with an open bank went unflagged.");
endmodule // xbcr_top

// [tb/test_xbcr_top.sv]
// Self-checking bench for the cross-bank command checker.
// Assumes the controller model drives the link pins on the memory clock it generates, apart from the system clock.
`timescale 1ns/1ps
module test_xbcr_top
    import xbcr_pkg::*;
;
    logic clk_sys, reset, err_clear, mem_clk, cke, cs_n, ras_n, cas_n, we_n, ap;
    logic self_refresh, state_error, timing_error;
    logic [2:0] ba;
    logic [7:0] bank_idle, bank_open;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    xbcr_top xbcr_top_inst (.clk_sys(clk_sys), .reset(reset), .mem_clk(mem_clk), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .auto_precharge_addr_bit(ap), .err_clear(err_clear), .bank_idle(bank_idle),
        .bank_open(bank_open), .self_refresh(self_refresh), .state_error(state_error),
        .timing_error(timing_error));
    xbcr_ctrl_model xbcr_ctrl_model_inst (.mem_clk(mem_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .auto_precharge_addr_bit(ap));
    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Whole run takes a few microseconds; the ceiling leaves ample margin.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Status crosses domains, so allow the synchroniser lag before looking.
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic clear_err();
        @(negedge clk_sys);
        err_clear = 1'h1;
        @(negedge clk_sys);
        err_clear = 1'h0;
        settle(6);
        check("errors", {6'h00, state_error, timing_error}, 8'h00);
    endtask
    task automatic t_reset();
        check("bank_idle", bank_idle, 8'hFF);
        check("bank_open", bank_open, 8'h00);
        check("status", {5'h00, self_refresh, state_error, timing_error}, 8'h00);
    endtask
    task automatic t_select();
        xbcr_ctrl_model_inst.set_cke(1'h1);
        xbcr_ctrl_model_inst.idle(4);
        xbcr_ctrl_model_inst.issue(CMD_NOP, 3'h2, 1'h0, 1'h1, 2);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h2, 1'h0, 1'h0, 2);
        settle(10);
        check("bank_idle", bank_idle, 8'hFF);
        check("state_error", {7'h00, state_error}, 8'h00);
        xbcr_ctrl_model_inst.set_cke(1'h0);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h2, 1'h0, 1'h1, 2);
        settle(10);
        check("bank_idle", bank_idle, 8'hFF);
        xbcr_ctrl_model_inst.set_cke(1'h1);
        xbcr_ctrl_model_inst.idle(4);
    endtask
    task automatic t_walk();
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h3, 1'h0, 1'h1, 1);
        settle(10);
        check("bank_open", bank_open, 8'h08);
        xbcr_ctrl_model_inst.issue(CMD_READ, 3'h3, 1'h1, 1'h1, 1);
        settle(8);
        check("bank_open", bank_open, 8'h00);
        check("bank_idle", bank_idle, 8'hF7);
        settle(30);
        check("bank_idle", bank_idle, 8'hFF);
    endtask
    task automatic t_wr_ap();
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h1, 1'h0, 1'h1, 1);
        xbcr_ctrl_model_inst.issue(CMD_WRITE, 3'h1, 1'h1, 1'h1, 0);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h5, 1'h0, 1'h1, 1);
        settle(10);
        check("bank_open", bank_open, 8'h20);
        check("bank_idle", bank_idle, 8'hDD);
        check("state_error", {7'h00, state_error}, 8'h00);
        settle(30);
        check("bank_idle", bank_idle, 8'hDF);
    endtask
    task automatic t_gaps();
        xbcr_cmd_t a1[4] = '{CMD_READ, CMD_WRITE, CMD_READ, CMD_WRITE};
        xbcr_cmd_t a2[4] = '{CMD_READ, CMD_WRITE, CMD_WRITE, CMD_READ};
        int lim[4] = '{HALF_BURST_CYC, HALF_BURST_CYC, RD_TO_WR_CYC, WR_TO_RD_CYC};
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h0, 1'h0, 1'h1, 0);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h1, 1'h0, 1'h1, 2);
        for (int i = 0; i < 4; i++)
        begin
            for (int d = 0; d < 2; d++)
            begin
                xbcr_ctrl_model_inst.issue(a1[i], 3'h0, 1'h0, 1'h1, lim[i] - 1 - d);
                xbcr_ctrl_model_inst.issue(a2[i], 3'h1, 1'h0, 1'h1, 12);
                settle(10);
                check("timing_error", {7'h00, timing_error}, {7'h00, d == 1});
                clear_err();
            end
        end
    endtask
    task automatic t_illegal();
        xbcr_cmd_t ic[3] = '{CMD_READ, CMD_REFRESH, CMD_RSVD};
        for (int i = 0; i < 3; i++)
        begin
            xbcr_ctrl_model_inst.issue(ic[i], 3'h6, 1'h0, 1'h1, 2);
            settle(10);
            check("state_error", {7'h00, state_error}, 8'h01);
            clear_err();
        end
        xbcr_ctrl_model_inst.issue(CMD_PRECHARGE, 3'h0, 1'h1, 1'h1, 4);
        settle(10);
        check("bank_idle", bank_idle, 8'hFF);
        xbcr_ctrl_model_inst.issue(CMD_REFRESH, 3'h0, 1'h0, 1'h1, 2);
        xbcr_ctrl_model_inst.issue(CMD_LOAD_MODE, 3'h0, 1'h0, 1'h1, 2);
        settle(10);
        check("state_error", {7'h00, state_error}, 8'h00);
    endtask
    // An activate inside the exit delay must be ignored; one after it must open the bank.
    task automatic t_self_ref();
        xbcr_ctrl_model_inst.sr_enter();
        settle(10);
        check("self_refresh", {7'h00, self_refresh}, 8'h01);
        xbcr_ctrl_model_inst.set_cke(1'h1);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h2, 1'h0, 1'h1, 10);
        settle(10);
        check("bank_idle", bank_idle, 8'hFF);
        check("self_refresh", {7'h00, self_refresh}, 8'h00);
        xbcr_ctrl_model_inst.issue(CMD_ACTIVATE, 3'h2, 1'h0, 1'h1, 2);
        settle(10);
        check("bank_open", bank_open, 8'h04);
    endtask
    initial
    begin
        reset = 1'h1;
        err_clear = 1'h0;
        settle(10);
        t_reset();
        reset = 1'h0;
        t_select();
        t_walk();
        t_wr_ap();
        t_gaps();
        t_illegal();
        t_self_ref();
        print_verdict();
    end
endmodule // test_xbcr_top

// [tb/xbcr_ctrl_model.sv]
// Controller model: free-running memory clock and command pins.
// Assumes the bench calls one task at a time and ends each run of commands with idle cycles.
`timescale 1ns/1ps
module xbcr_ctrl_model
    import xbcr_pkg::*;
(
    output logic mem_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic auto_precharge_addr_bit
);
    initial
    begin
        mem_clk = 1'h0;
        #3.3;
        forever #7.5 mem_clk = ~mem_clk;
    end
    initial
    begin
        cke = 1'h0;
        {cs_n, ras_n, cas_n, we_n, ba, auto_precharge_addr_bit} = 8'hFE;
    end
    // Deselected cycles scramble the strobes, so a stale code never passes for a command.
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge mem_clk);
            cs_n = 1'h1;
            {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
            ba = ~ba;
        end
    endtask
    task automatic issue(input xbcr_cmd_t c, input logic [2:0] b, input logic a,
        input logic s, input int n);
        @(negedge mem_clk);
        cs_n = ~s;
        {ras_n, cas_n, we_n} = c;
        ba = b;
        auto_precharge_addr_bit = a;
        @(posedge mem_clk);
        idle(n);
    endtask
    // Refresh with clock enable falling on the same edge enters self refresh.
    task automatic sr_enter();
        @(negedge mem_clk);
        cke = 1'h0;
        cs_n = 1'h0;
        {ras_n, cas_n, we_n} = CMD_REFRESH;
        @(posedge mem_clk);
        idle(2);
    endtask
    task automatic set_cke(input logic v);
        @(negedge mem_clk);
        cke = v;
    endtask
endmodule // xbcr_ctrl_model
